// ---- hdl/igf_top.sv ----
// interrupt groups, unit select and pin filters behind axi4-lite
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "igf_defs.svh"

// Contract
// - eight groups merge sources onto shared vectors
// - groups zero to six latch rising edges
// - group twelve slot follows level error sources; its pending bit stays set until cleared while the source is low
// - active source sets its group pending bit
// - pending and enabled source raises group vector
// - writing clear bit drops pending bit
// - only selected timer drives shared vectors
// - unit zero picks timer channel zero/six
// - filter samples at clock, /8, /32, /64
// - pulses under three samples are suppressed
// - filtered transition lags raw pin change
// - filter optional; disabled pin passes through
module igf_top #(
    parameter int NUM_GROUPS = 8,
    parameter int SRC_W = 32,
    parameter int UNIT_W = 6,
    parameter int NUM_PINS = 16
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // peripheral sources, same clock domain
    input wire logic [NUM_GROUPS*SRC_W-1:0] group_src_in,
    input wire logic [UNIT_W-1:0] multifunction_timer_channel_zero_in,
    input wire logic [UNIT_W-1:0] pulse_timer_channel_six_in,
    // raw external request pins
    input wire logic [NUM_PINS-1:0] irq_pin_in,
    // toward the core vector logic
    output logic [NUM_GROUPS-1:0] group_vector_out,
    output logic [UNIT_W-1:0] unit_vector_out,
    output logic [NUM_PINS-1:0] pin_level_out,
    output logic irq_out,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    // bank number of a byte address
    function automatic logic [2:0] addr_bank(input logic [7:0] a);
        addr_bank = a[7:5];
    endfunction : addr_bank
    // group index of a byte address inside a bank
    function automatic logic [2:0] addr_slot(input logic [7:0] a);
        addr_slot = a[4:2];
    endfunction : addr_slot
    // byte strobes expanded to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask
    logic aw_full_reg, aw_full_next; // write address held
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic w_full_reg, w_full_next; // write data held
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic do_write; // both halves present, response slot free
    logic do_read; // read address accepted this cycle
    logic wr_hit; // write address decodes to a register
    logic rd_hit; // read address decodes to a register
    logic [31:0] rd_word; // data for the read address
    logic [31:0] wmask; // byte lanes of the held write
    logic [SRC_W-1:0] pend_reg [NUM_GROUPS];
    logic [SRC_W-1:0] pend_next [NUM_GROUPS];
    logic [SRC_W-1:0] en_reg [NUM_GROUPS];
    logic [SRC_W-1:0] en_next [NUM_GROUPS];
    logic [SRC_W-1:0] src_prev_reg [NUM_GROUPS]; // last source levels for edge detect
    logic [NUM_GROUPS-1:0] gvec_reg, gvec_next;
    logic usel_reg, usel_next; // 0 selects the multifunction timer
    logic [UNIT_W-1:0] uvec_reg, uvec_next;
    logic [NUM_PINS-1:0] fen_reg, fen_next; // per pin filter enable
    logic [2*NUM_PINS-1:0] fsel_reg, fsel_next; // two rate bits per pin
    logic [NUM_PINS-1:0] istat_reg, istat_next; // sticky pin edge events
    logic [NUM_PINS-1:0] imask_reg, imask_next;
    logic irq_reg, irq_next;
    logic [NUM_PINS-1:0] pin_meta_reg; // first synchroniser stage
    logic [NUM_PINS-1:0] pin_sync_reg; // second synchroniser stage
    logic [5:0] div_cnt_reg, div_cnt_next; // shared sampling prescaler
    logic [`IGF_FILT_SAMPLES-1:0] hist_reg [NUM_PINS];
    logic [`IGF_FILT_SAMPLES-1:0] hist_next [NUM_PINS];
    logic [NUM_PINS-1:0] filt_reg, filt_next; // recognised pin levels

    // address and data taken in either order, held until both are here
    always_comb begin
        do_write = aw_full_reg && w_full_reg && !bvalid_reg;
        do_read = s_axi_arvalid_in && arready_reg;
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
        end else begin
            if (s_axi_awvalid_in && awready_reg) begin
                aw_full_next = 1'b1;
                aw_addr_next = s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && wready_reg) begin
                w_full_next = 1'b1;
                w_data_next = s_axi_wdata_in;
                w_strb_next = s_axi_wstrb_in;
            end
        end
        // response stands until the master takes it
        bvalid_next = do_write || (bvalid_reg && !s_axi_bready_in);
        bresp_next = bresp_reg;
        if (do_write) begin
            bresp_next = wr_hit ? `IGF_RESP_OKAY : `IGF_RESP_SLVERR;
        end
        // ready drops while a half is held, so one write at most is in flight
        awready_next = !aw_full_next && !bvalid_next;
        wready_next = !w_full_next && !bvalid_next;
        rvalid_next = do_read || (rvalid_reg && !s_axi_rready_in);
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (do_read) begin
            rdata_next = rd_word;
            rresp_next = rd_hit ? `IGF_RESP_OKAY : `IGF_RESP_SLVERR;
        end
        arready_next = !rvalid_next;
    end

    // axi channel registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `IGF_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= `IGF_RST_WORD;
            rresp_reg <= `IGF_RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // unmapped address: zero data, slave error
    always_comb begin
        rd_word = `IGF_RST_WORD;
        rd_hit = 1'b1;
        if (addr_bank(s_axi_araddr_in) == `IGF_BANK_PEND) begin
            rd_word = 32'(pend_reg[addr_slot(s_axi_araddr_in)]);
        end else if (addr_bank(s_axi_araddr_in) == `IGF_BANK_EN) begin
            rd_word = 32'(en_reg[addr_slot(s_axi_araddr_in)]);
        end else if (addr_bank(s_axi_araddr_in) == `IGF_BANK_CLR) begin
            rd_word = `IGF_RST_WORD; // clear bank is write only
        end else if (s_axi_araddr_in == `IGF_OFS_USEL) begin
            rd_word = 32'(usel_reg);
        end else if (s_axi_araddr_in == `IGF_OFS_FEN) begin
            rd_word = 32'(fen_reg);
        end else if (s_axi_araddr_in == `IGF_OFS_FSEL) begin
            rd_word = 32'(fsel_reg);
        end else if (s_axi_araddr_in == `IGF_OFS_ISTAT) begin
            rd_word = 32'(istat_reg);
        end else if (s_axi_araddr_in == `IGF_OFS_IMASK) begin
            rd_word = 32'(imask_reg);
        end else if (s_axi_araddr_in == `IGF_OFS_PINLVL) begin
            rd_word = 32'(filt_reg);
        end else begin
            rd_hit = 1'b0;
        end
        if (s_axi_araddr_in[1:0] != 2'h0) begin
            rd_hit = 1'b0; // misaligned
            rd_word = `IGF_RST_WORD;
        end
    end
    // a source event in the same cycle as its clear keeps the bit set
    always_comb begin
        wmask = strb_mask(w_strb_reg);
        wr_hit = (aw_addr_reg[1:0] == 2'h0) && (addr_bank(aw_addr_reg) <= `IGF_BANK_CLR
            || aw_addr_reg == `IGF_OFS_USEL || aw_addr_reg == `IGF_OFS_FEN
            || aw_addr_reg == `IGF_OFS_FSEL || aw_addr_reg == `IGF_OFS_ISTAT
            || aw_addr_reg == `IGF_OFS_IMASK || aw_addr_reg == `IGF_OFS_PINLVL);
        usel_next = usel_reg;
        fen_next = fen_reg;
        fsel_next = fsel_reg;
        imask_next = imask_reg;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            logic [SRC_W-1:0] cur_src;
            logic [SRC_W-1:0] set_bits;
            logic [SRC_W-1:0] clr_bits;
            set_bits = '0;
            clr_bits = '0;
            cur_src = group_src_in[g*SRC_W +: SRC_W];
            // level slot is set while the source is high; other slots catch rising edges
            if (g == `IGF_LEVEL_SLOT) begin
                set_bits = cur_src;
            end else begin
                set_bits = cur_src & ~src_prev_reg[g];
            end
            en_next[g] = en_reg[g];
            if (do_write && wr_hit && addr_slot(aw_addr_reg) == 3'(g)) begin
                if (addr_bank(aw_addr_reg) == `IGF_BANK_CLR) begin
                    clr_bits = SRC_W'(w_data_reg & wmask);
                end else if (addr_bank(aw_addr_reg) == `IGF_BANK_EN) begin
                    en_next[g] = SRC_W'((32'(en_reg[g]) & ~wmask) | (w_data_reg & wmask));
                end
            end
            pend_next[g] = (pend_reg[g] & ~clr_bits) | set_bits;
            // merged vector of the group, only enabled sources count
            gvec_next[g] = |(pend_reg[g] & en_reg[g]);
        end
        if (do_write && aw_addr_reg == `IGF_OFS_USEL) begin
            usel_next = w_data_reg[`IGF_USEL_BIT] & wmask[`IGF_USEL_BIT];
        end else if (do_write && aw_addr_reg == `IGF_OFS_FEN) begin
            fen_next = NUM_PINS'((32'(fen_reg) & ~wmask) | (w_data_reg & wmask));
        end else if (do_write && aw_addr_reg == `IGF_OFS_FSEL) begin
            fsel_next = (2*NUM_PINS)'((32'(fsel_reg) & ~wmask) | (w_data_reg & wmask));
        end else if (do_write && aw_addr_reg == `IGF_OFS_IMASK) begin
            imask_next = NUM_PINS'((32'(imask_reg) & ~wmask) | (w_data_reg & wmask));
        end
        // shared vectors carry one timer only, the other is ignored
        uvec_next = usel_reg ? pulse_timer_channel_six_in
            : multifunction_timer_channel_zero_in;
    end

    // group and control registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                pend_reg[g] <= '0;
                en_reg[g] <= '0;
                src_prev_reg[g] <= '0;
            end
            gvec_reg <= '0;
            usel_reg <= 1'b0;
            uvec_reg <= '0;
            fen_reg <= '0;
            fsel_reg <= '0;
            imask_reg <= '0;
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                pend_reg[g] <= pend_next[g];
                en_reg[g] <= en_next[g];
                src_prev_reg[g] <= group_src_in[g*SRC_W +: SRC_W];
            end
            gvec_reg <= gvec_next;
            usel_reg <= usel_next;
            uvec_reg <= uvec_next;
            fen_reg <= fen_next;
            fsel_reg <= fsel_next;
            imask_reg <= imask_next;
        end
    end

    // one prescaler feeds the /8, /32 and /64 rates so pins on the same rate sample together
    always_comb begin
        div_cnt_next = div_cnt_reg + 6'h01;
        for (int p = 0; p < NUM_PINS; p++) begin
            logic smp;
            smp = 1'b0;
            case (igf_pkg::igf_rate_t'(fsel_reg[2*p +: 2]))
                igf_pkg::IGF_RATE_DIV1: smp = 1'b1;
                igf_pkg::IGF_RATE_DIV8: smp = (div_cnt_reg & `IGF_DIV8_MASK) == `IGF_DIV8_MASK;
                igf_pkg::IGF_RATE_DIV32: smp = (div_cnt_reg & `IGF_DIV32_MASK) == `IGF_DIV32_MASK;
                igf_pkg::IGF_RATE_DIV64: smp = div_cnt_reg == `IGF_DIV64_MASK;
                default: smp = 1'b0;
            endcase
            hist_next[p] = hist_reg[p];
            filt_next[p] = filt_reg[p];
            if (!fen_reg[p]) begin
                // bypass: synchronised pin passes
                filt_next[p] = pin_sync_reg[p];
                hist_next[p] = {`IGF_FILT_SAMPLES{pin_sync_reg[p]}};
            end else if (smp) begin
                hist_next[p] = {hist_reg[p][`IGF_FILT_SAMPLES-2:0], pin_sync_reg[p]};
                // level changes only after three equal samples, adding latency
                if (&hist_next[p]) begin
                    filt_next[p] = 1'b1;
                end else if (~|hist_next[p]) begin
                    filt_next[p] = 1'b0;
                end
            end
        end
        // any recognised change of a pin sets its sticky event; a read clears
        istat_next = istat_reg;
        if (do_read && s_axi_araddr_in == `IGF_OFS_ISTAT) begin
            istat_next = '0;
        end
        istat_next = istat_next | (filt_next ^ filt_reg);
        irq_next = |(istat_next & imask_next);
    end

    // pin filter registers; the first stage feeds only the second
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            div_cnt_reg <= 6'h00;
            for (int p = 0; p < NUM_PINS; p++) begin
                hist_reg[p] <= '0;
            end
            filt_reg <= '0;
            istat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            pin_meta_reg <= irq_pin_in;
            pin_sync_reg <= pin_meta_reg;
            div_cnt_reg <= div_cnt_next;
            for (int p = 0; p < NUM_PINS; p++) begin
                hist_reg[p] <= hist_next[p];
            end
            filt_reg <= filt_next;
            istat_reg <= istat_next;
            irq_reg <= irq_next;
        end
    end

    // outputs, all straight from flip-flops
    assign group_vector_out = gvec_reg;
    assign unit_vector_out = uvec_reg;
    assign pin_level_out = filt_reg;
    assign irq_out = irq_reg;
    assign s_axi_awready_out = awready_reg;
    assign s_axi_wready_out = wready_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_arready_out = arready_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;
endmodule : igf_top

// ---- hdl/igf_defs.svh ----
// constants of the interrupt group and pin filter
`ifndef IGF_DEFS_SVH
`define IGF_DEFS_SVH

// bank base offsets, one word per group
`define IGF_OFS_PEND 8'h00
`define IGF_OFS_EN 8'h20
`define IGF_OFS_CLR 8'h40
// single register offsets
`define IGF_OFS_USEL 8'h60
`define IGF_OFS_FEN 8'h64
`define IGF_OFS_FSEL 8'h68
`define IGF_OFS_ISTAT 8'h6c
`define IGF_OFS_IMASK 8'h70
`define IGF_OFS_PINLVL 8'h74

// bank number in address bits 7:5
`define IGF_BANK_PEND 3'h0
`define IGF_BANK_EN 3'h1
`define IGF_BANK_CLR 3'h2

// slot of level error group twelve
`define IGF_LEVEL_SLOT 7

// unit select field
`define IGF_USEL_BIT 0

// divider masks: sample when masked count is all ones
`define IGF_DIV8_MASK 6'h07
`define IGF_DIV32_MASK 6'h1f
`define IGF_DIV64_MASK 6'h3f

// equal samples before a filtered level changes
`define IGF_FILT_SAMPLES 3

// axi responses
`define IGF_RESP_OKAY 2'h0
`define IGF_RESP_SLVERR 2'h2

// reset values
`define IGF_RST_WORD 32'h0000_0000

`endif

// ---- hdl/igf_pkg.sv ----
// types shared by the interrupt group and pin filter block
package igf_pkg;

    // sampling rate of one pin filter
    typedef enum logic [1:0] {
        IGF_RATE_DIV1,
        IGF_RATE_DIV8,
        IGF_RATE_DIV32,
        IGF_RATE_DIV64
    } igf_rate_t;

endpackage : igf_pkg

// ---- verif/igf_chk_properties.sv ----
// port-level assertions for the interrupt group and pin filter
`timescale 1ns/100ps
module igf_chk #(
    parameter int UNIT_W = 6,
    parameter int NUM_PINS = 16
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [UNIT_W-1:0] multifunction_timer_channel_zero_in,
    input wire logic [UNIT_W-1:0] pulse_timer_channel_six_in,
    input wire logic [NUM_PINS-1:0] irq_pin_in,
    input wire logic [UNIT_W-1:0] unit_vector_out,
    input wire logic [NUM_PINS-1:0] pin_level_out,
    input wire logic irq_out,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    // single clock domain
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // shared vectors carry one timer, one cycle late
    AST_UNIT_ONE_OF: assert property (unit_vector_out != '0 |->
        unit_vector_out == $past(multifunction_timer_channel_zero_in)
        || unit_vector_out == $past(pulse_timer_channel_six_in))
        else $error("unit from neither timer");
    AST_UNIT_QUIET: assert property (multifunction_timer_channel_zero_in == '0
        && pulse_timer_channel_six_in == '0 |=> unit_vector_out == '0)
        else $error("unit vector without source");
    // a recognised rise needs the raw pin high before
    AST_PIN_CAUSE: assert property ($rose(pin_level_out[0]) |->
        $past(irq_pin_in[0], 3) || $past(irq_pin_in[0], 4))
        else $error("level rose without pin");
    AST_IRQ_CAUSE: assert property ($rose(irq_out) |->
        pin_level_out != $past(pin_level_out))
        else $error("irq rose without event");
    AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
        else $error("rvalid dropped");
    AST_W_BLOCK: assert property (s_axi_bvalid_out |->
        !s_axi_awready_out && !s_axi_wready_out)
        else $error("write ready during bvalid");
    AST_AR_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read ready during rvalid");
    AST_B_LAT: assert property (s_axi_awvalid_in && s_axi_awready_out
        && s_axi_wvalid_in && s_axi_wready_out |=> ##1 s_axi_bvalid_out)
        else $error("bvalid late");
    AST_R_LAT: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("rvalid late");
endmodule : igf_chk

bind igf_top igf_chk #(.UNIT_W(UNIT_W), .NUM_PINS(NUM_PINS)) igf_chk_inst (.*);

// ---- verif/igf_periph_model.sv ----
// behavioural peripheral sources, timers and external request pins
`timescale 1ns/100ps
module igf_periph_model (
    input wire logic ref_clk_in,
    output logic [255:0] src_out = '0,
    output logic [5:0] tmr_a_out = '0,
    output logic [5:0] tmr_b_out = '0,
    output logic [15:0] pin_out = '0
);
    // one-cycle event, as the edge sources give
    task automatic pulse_src(input int g, input int b);
        @(posedge ref_clk_in);
        src_out[g*32+b] <= 1'b1;
        @(posedge ref_clk_in);
        src_out[g*32+b] <= 1'b0;
    endtask : pulse_src

    // error sources stay up until serviced
    task automatic hold_src(input int g, input int b, input logic v);
        @(posedge ref_clk_in);
        src_out[g*32+b] <= v;
    endtask : hold_src

    task automatic set_timers(input logic [5:0] a, input logic [5:0] b);
        @(posedge ref_clk_in);
        tmr_a_out <= a;
        tmr_b_out <= b;
    endtask : set_timers

    task automatic pin_set(input logic v);
        @(posedge ref_clk_in);
        pin_out[0] <= v;
    endtask : pin_set

    // glitch of w cycles on pin zero
    task automatic pin_pulse(input int w);
        pin_set(1'b1);
        repeat (w) @(posedge ref_clk_in);
        pin_out[0] <= 1'b0;
    endtask : pin_pulse
endmodule : igf_periph_model

// ---- verif/tb_igf_top.sv ----
// self-checking bench for the interrupt group and pin filter
`timescale 1ns/100ps
`include "igf_defs.svh"
module tb_igf_top;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [255:0] group_src_in;
    logic [5:0] multifunction_timer_channel_zero_in, pulse_timer_channel_six_in;
    logic [15:0] irq_pin_in, pin_level_out;
    logic [7:0] group_vector_out;
    logic [5:0] unit_vector_out;
    logic irq_out, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
    logic [31:0] s_axi_rdata_out, rd;
    logic [7:0] s_axi_awaddr_in = 8'h00;
    logic [7:0] s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    int n_mismatch = 0;
    int checks_done = 0;
    int divs[4] = '{1, 8, 32, 64};
    logic [7:0] regs[9] = '{`IGF_OFS_PEND, `IGF_OFS_EN, `IGF_OFS_CLR, `IGF_OFS_USEL,
        `IGF_OFS_FEN, `IGF_OFS_FSEL, `IGF_OFS_ISTAT, `IGF_OFS_IMASK, `IGF_OFS_PINLVL};

    always #2.5 ref_clk_in = ~ref_clk_in;

    igf_top igf_top_inst (.*);
    igf_periph_model igf_periph_model_inst (.ref_clk_in(ref_clk_in), .src_out(group_src_in),
        .tmr_a_out(multifunction_timer_channel_zero_in),
        .tmr_b_out(pulse_timer_channel_six_in), .pin_out(irq_pin_in));

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // a used-up wait bound ends the run
    task automatic guard(input logic hit);
        if (hit) begin
            n_mismatch++;
            $display("ERROR handshake expected 1 seen 0");
            test_done();
        end
    endtask : guard

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : settle

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out && n < 200);
        rsp = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        guard(n >= 200);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int n = 0;
        @(posedge ref_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out && n < 200);
        rd = s_axi_rdata_out;
        rsp = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        guard(n >= 200);
    endtask : axi_rd

    task automatic wait_pin(input logic v, input int lim);
        int n = 0;
        while (pin_level_out[0] !== v && n < lim) begin
            settle(1);
            n++;
        end
        guard(n >= lim);
    endtask : wait_pin

    initial begin
        repeat (6) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        // the nine listed words read zero after reset
        foreach (regs[i]) begin
            axi_rd(regs[i]);
            chk("reset word", `IGF_RST_WORD, rd);
        end
        axi_rd(8'h80);
        chk("unmapped read resp", 32'(`IGF_RESP_SLVERR), 32'(rsp));
        chk("unmapped read data", 32'h0, rd);
        axi_wr(8'h84, 32'hffff_ffff);
        chk("unmapped write resp", 32'(`IGF_RESP_SLVERR), 32'(rsp));
        $display("test registers done");
        // per edge group: source g enabled, g+1 not
        for (int g = 0; g < 7; g++) begin
            axi_wr(`IGF_OFS_EN + 8'(4 * g), 32'h1 << g);
            igf_periph_model_inst.pulse_src(g, g);
            igf_periph_model_inst.pulse_src(g, g + 1);
            settle(4);
            chk("group vectors", (32'h2 << g) - 32'h1, 32'(group_vector_out));
        end
        // handler: inspect and clear each pending source
        for (int g = 0; g < 7; g++) begin
            axi_rd(`IGF_OFS_PEND + 8'(4 * g));
            chk("pending latched", 32'h3 << g, rd);
            axi_wr(`IGF_OFS_CLR + 8'(4 * g), 32'h1 << g);
            settle(3);
            chk("cleared vector", 32'h0, 32'(group_vector_out[g]));
            axi_wr(`IGF_OFS_CLR + 8'(4 * g), 32'h2 << g);
            axi_rd(`IGF_OFS_PEND + 8'(4 * g));
            chk("pending cleared", 32'h0, rd);
        end
        $display("test edge groups done");
        // level slot: clear cannot drop a high source
        igf_periph_model_inst.hold_src(`IGF_LEVEL_SLOT, 3, 1'b1);
        axi_wr(`IGF_OFS_EN + 8'h1c, 32'h8);
        axi_wr(`IGF_OFS_CLR + 8'h1c, 32'h8);
        axi_rd(`IGF_OFS_PEND + 8'h1c);
        chk("level pending", 32'h8, rd);
        chk("level vector", 32'h1, 32'(group_vector_out[7]));
        igf_periph_model_inst.hold_src(`IGF_LEVEL_SLOT, 3, 1'b0);
        axi_wr(`IGF_OFS_CLR + 8'h1c, 32'h8);
        axi_rd(`IGF_OFS_PEND + 8'h1c);
        chk("level released", 32'h0, rd);
        $display("test level group done");
        igf_periph_model_inst.set_timers(6'h15, 6'h2a);
        for (int u = 0; u < 2; u++) begin
            axi_wr(`IGF_OFS_USEL, 32'(u));
            settle(3);
            chk("unit vector", (u == 0) ? 32'h15 : 32'h2a, 32'(unit_vector_out));
        end
        $display("test unit select done");
        // per rate: two-sample glitch dropped, held level late
        axi_wr(`IGF_OFS_FEN, 32'h1);
        for (int r = 0; r < 4; r++) begin
            axi_wr(`IGF_OFS_FSEL, 32'(r));
            igf_periph_model_inst.pin_pulse(2 * divs[r]);
            settle(4 * divs[r] + 8);
            chk("glitch level", 32'h0, 32'(pin_level_out[0]));
            igf_periph_model_inst.pin_set(1'b1);
            settle(2 * divs[r]);
            chk("filter lag", 32'h0, 32'(pin_level_out[0]));
            wait_pin(1'b1, 4 * divs[r] + 10);
            igf_periph_model_inst.pin_set(1'b0);
            wait_pin(1'b0, 4 * divs[r] + 10);
        end
        chk("irq masked", 32'h0, 32'(irq_out));
        $display("test filter done");
        axi_rd(`IGF_OFS_ISTAT);
        axi_wr(`IGF_OFS_FEN, 32'h0);
        axi_wr(`IGF_OFS_IMASK, 32'h1);
        igf_periph_model_inst.pin_set(1'b1);
        settle(4);
        chk("bypass level", 32'h1, 32'(pin_level_out[0]));
        chk("irq raised", 32'h1, 32'(irq_out));
        axi_rd(`IGF_OFS_ISTAT);
        chk("event status", 32'h1, rd);
        settle(2);
        chk("irq after read", 32'h0, 32'(irq_out));
        $display("test bypass and irq done");
        test_done();
    end
endmodule : tb_igf_top
